// ---- hdl/rgc_top.sv ----
// rgc_top: apb register file, automatic gain sequencer, bandwidth and dc-cut selection.
// assumes strength estimate and fifo-empty come from same-clock logic; converter bits are async.
`default_nettype none
module rgc_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] signal_strength_value,
    input wire logic strength_valid,
    input wire logic fifo_empty,
    input wire logic packet_done,
    input wire logic adc_i_bit,
    input wire logic adc_q_bit,
    output logic [2:0] amp_gain,
    output logic input_impedance_sel,
    output logic [4:0] filter_mant,
    output logic [3:0] filter_shift,
    output logic [2:0] dc_cancel_cutoff_field,
    output logic [11:0] sample_i,
    output logic [11:0] sample_q
);
    import rgc_pkg::*;
    // ==========================================
    // registers
    logic [7:0] amp_control_reg;
    logic [7:0] strength_threshold_reg;
    logic [7:0] bandwidth_reg;
    logic [7:0] corr_bw_reg;
    logic [7:0] digital_gain_ctrl_reg;
    logic [15:0] control_reg;
    logic [15:0] bit_period_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic pready_reg;
    logic [2:0] current_gain_reg;
    logic [1:0] above_cnt_reg;
    logic [7:0] strength_latched_reg;
    logic [15:0] bit_cnt_reg;
    logic bit_tick;
    logic [1:0] two_bit_reg;
    logic [7:0] delay_cnt_reg;
    logic delay_arm_reg;
    logic corr_phase_reg;
    wire logic [1:0][11:0] sample_rail;
    rgc_state_t state_reg;
    rgc_state_t state_next;
    logic [2:0] amp_gain_reg;
    logic [4:0] mant_out_reg;
    logic [3:0] shift_out_reg;
    logic [2:0] dcc_out_reg;
    logic imp_reg;
    logic wr_en;
    logic restart_wr;
    logic [4:0] mant_value;
    logic [3:0] shift_total;
    logic [6:0] ref_db;
    logic [2:0] gain_pick;
    logic digital_gain_adjust_en;
    rgc_bw_cfg_t bw_cfg;
    // ==========================================
    // apb slave, zero wait states
    assign wr_en = psel && penable && pwrite;
    assign restart_wr = wr_en && paddr == RGC_CONTROL_OFF && pwdata[RGC_RESTART_BIT];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp_control_reg <= RGC_AMP_RESET;
            strength_threshold_reg <= RGC_THRESH_RESET;
            bandwidth_reg <= RGC_BW_RESET;
            corr_bw_reg <= RGC_CORR_BW_RESET;
            digital_gain_ctrl_reg <= RGC_DIG_GAIN_RESET;
            control_reg <= 16'h0000;
            bit_period_reg <= RGC_BIT_PERIOD_RESET;
        end else begin
            if (wr_en) begin
                if (paddr == RGC_AMP_CONTROL_OFF) begin
                    amp_control_reg <= pwdata[7:0];
                end else if (paddr == RGC_THRESHOLD_OFF) begin
                    strength_threshold_reg <= pwdata[7:0];
                end else if (paddr == RGC_BANDWIDTH_OFF) begin
                    bandwidth_reg <= pwdata[7:0];
                end else if (paddr == RGC_CORR_BW_OFF) begin
                    corr_bw_reg <= pwdata[7:0];
                end else if (paddr == RGC_DIG_GAIN_OFF) begin
                    digital_gain_ctrl_reg <= pwdata[7:0];
                end else if (paddr == RGC_CONTROL_OFF) begin
                    control_reg <= pwdata[15:0];
                end else if (paddr == RGC_BIT_PERIOD_OFF) begin
                    bit_period_reg <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
                end
            end
            // the write wins only if it lands in the same cycle
            if (state_reg == RGC_ST_WAIT && !restart_wr) begin
                control_reg[RGC_RESTART_BIT] <= 1'b0;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= psel && !penable;
            pslverr_reg <= psel && !penable && (paddr[1:0] != 2'b00 || paddr > RGC_BIT_PERIOD_OFF);
            if (psel && !penable && !pwrite) begin
                if (paddr == RGC_AMP_CONTROL_OFF) begin
                    prdata_reg <= {24'h0, amp_control_reg[7:6], current_gain_reg, amp_control_reg[2:0]};
                end else if (paddr == RGC_THRESHOLD_OFF) begin
                    prdata_reg <= {24'h0, strength_threshold_reg};
                end else if (paddr == RGC_BANDWIDTH_OFF) begin
                    prdata_reg <= {24'h0, bandwidth_reg};
                end else if (paddr == RGC_CORR_BW_OFF) begin
                    prdata_reg <= {24'h0, corr_bw_reg};
                end else if (paddr == RGC_DIG_GAIN_OFF) begin
                    prdata_reg <= {24'h0, digital_gain_ctrl_reg};
                end else if (paddr == RGC_CONTROL_OFF) begin
                    prdata_reg <= {16'h0, control_reg};
                end else if (paddr == RGC_STATUS_OFF) begin
                    prdata_reg <= {16'h0, strength_latched_reg, 4'h0, state_reg};
                end else if (paddr == RGC_REF_LEVEL_OFF) begin
                    prdata_reg <= {25'h0, ref_db};
                end else if (paddr == RGC_BIT_PERIOD_OFF) begin
                    prdata_reg <= {16'h0, bit_period_reg};
                end else begin
                    prdata_reg <= 32'h00000000;
                end
            end
        end
    end
    // ==========================================
    // bit timing
    assign bit_tick = bit_cnt_reg == 16'h0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_reg <= 16'h0000;
            two_bit_reg <= 2'h0;
        end else begin
            bit_cnt_reg <= bit_tick ? bit_period_reg - 16'h0001 : bit_cnt_reg - 16'h0001;
            if (bit_tick) begin
                two_bit_reg <= (two_bit_reg == 2'(RGC_DIGITAL_GAIN_ADJUST_BITS - 1)) ? 2'h0 : two_bit_reg + 2'h1;
            end
        end
    end
    // ==========================================
    // gain sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            above_cnt_reg <= 2'h0;
            strength_latched_reg <= 8'h00;
        end else if (state_reg != RGC_ST_WAIT) begin
            above_cnt_reg <= 2'h0;
        end else if (strength_valid) begin
            if (signal_strength_value > strength_threshold_reg) begin
                strength_latched_reg <= signal_strength_value;
                if (above_cnt_reg != 2'(RGC_CONSEC_NEEDED)) begin
                    above_cnt_reg <= above_cnt_reg + 2'h1;
                end
            end else begin
                above_cnt_reg <= 2'h0;
            end
        end
    end
    // strength above threshold in 12 dB steps picks lower gain
    always_comb begin
        logic [7:0] margin;
        margin = strength_latched_reg - strength_threshold_reg;
        if (margin < 8'd24) begin
            gain_pick = RGC_GAIN_MAX;
        end else if (margin < 8'd48) begin
            gain_pick = 3'h2;
        end else if (margin < 8'd72) begin
            gain_pick = 3'h3;
        end else if (margin < 8'd96) begin
            gain_pick = 3'h4;
        end else if (margin < 8'd120) begin
            gain_pick = 3'h5;
        end else begin
            gain_pick = RGC_GAIN_MIN;
        end
    end
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RGC_ST_IDLE: begin
                if (control_reg[RGC_RXEN_BIT]) begin
                    state_next = RGC_ST_WAIT;
                end
            end
            RGC_ST_WAIT: begin
                if (above_cnt_reg == 2'(RGC_CONSEC_NEEDED)) begin
                    state_next = RGC_ST_PICK;
                end
            end
            RGC_ST_PICK: begin
                state_next = RGC_ST_HOLD;
            end
            RGC_ST_HOLD: begin
                if (delay_arm_reg && delay_cnt_reg == 8'h00) begin
                    state_next = RGC_ST_WAIT;
                end
            end
            default: begin
                state_next = RGC_ST_IDLE;
            end
        endcase
        if (!control_reg[RGC_RXEN_BIT]) begin
            state_next = RGC_ST_IDLE;
        end else if (control_reg[RGC_RESTART_BIT] && state_reg != RGC_ST_WAIT) begin
            state_next = RGC_ST_WAIT;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RGC_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end
    // latched once per pick, held through hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            current_gain_reg <= RGC_GAIN_MAX;
        end else if (state_reg == RGC_ST_PICK) begin
            current_gain_reg <= gain_pick;
        end
    end
    // delay counts bit periods after fifo drained
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delay_arm_reg <= 1'b0;
            delay_cnt_reg <= 8'h00;
        end else if (state_reg != RGC_ST_HOLD) begin
            delay_arm_reg <= 1'b0;
        end else if (!delay_arm_reg) begin
            if (control_reg[RGC_PKTMODE_BIT] && control_reg[RGC_AUTORST_BIT] && packet_done && fifo_empty) begin
                delay_arm_reg <= 1'b1;
                delay_cnt_reg <= control_reg[RGC_DELAY_LSB +: 8];
            end
        end else if (bit_tick && delay_cnt_reg != 8'h00) begin
            delay_cnt_reg <= delay_cnt_reg - 8'(RGC_DELAY_UNIT);
        end
    end
    // correction window covers the first wait and pick after enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            corr_phase_reg <= 1'b0;
        end else if (state_reg == RGC_ST_IDLE) begin
            corr_phase_reg <= control_reg[RGC_CORR_BIT];
        end else if (state_reg == RGC_ST_HOLD) begin
            corr_phase_reg <= 1'b0;
        end
    end
    // ==========================================
    // bandwidth and outputs
    always_comb begin
        bw_cfg.mant_sel = {1'b0, corr_phase_reg ? corr_bw_reg[RGC_MANT_LSB +: 2] : bandwidth_reg[RGC_MANT_LSB +: 2]};
        bw_cfg.exponent = corr_phase_reg ? corr_bw_reg[RGC_EXP_LSB +: 3] : bandwidth_reg[RGC_EXP_LSB +: 3];
        bw_cfg.ook = control_reg[RGC_OOK_BIT];
    end
    rgc_bw_decode u_bw (
        .cfg(bw_cfg),
        .mant_value(mant_value),
        .shift_total(shift_total),
        .ref_db(ref_db)
    );
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp_gain_reg <= RGC_GAIN_MAX;
            mant_out_reg <= 5'd16;
            shift_out_reg <= 4'h2;
            dcc_out_reg <= 3'h2;
            imp_reg <= 1'b0;
        end else begin
            if (amp_control_reg[RGC_GSEL_LSB +: 3] == RGC_GAIN_AUTO) begin
                amp_gain_reg <= current_gain_reg;
            end else if (amp_control_reg[RGC_GSEL_LSB +: 3] != RGC_GAIN_RSVD) begin
                amp_gain_reg <= amp_control_reg[RGC_GSEL_LSB +: 3];
            end
            mant_out_reg <= mant_value;
            shift_out_reg <= shift_total;
            dcc_out_reg <= bandwidth_reg[RGC_DCC_LSB +: 3];
            imp_reg <= amp_control_reg[RGC_ZIN_BIT];
        end
    end
    // ==========================================
    // converter rails: three stages, change taken when stages two and three agree
    assign digital_gain_adjust_en = digital_gain_ctrl_reg[5];
    genvar r;
    generate
        for (r = 0; r < 2; r++) begin : g_rail
            logic [2:0] sync_reg;
            logic stable_reg;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_reg <= 3'h0;
                    stable_reg <= 1'b0;
                end else begin
                    sync_reg <= {sync_reg[1:0], (r == 0) ? adc_i_bit : adc_q_bit};
                    if (sync_reg[1] == sync_reg[2]) begin
                        stable_reg <= sync_reg[2];
                    end
                end
            end
            rgc_dsp_path u_path (
                .pclk(pclk),
                .presetn(presetn),
                .adc_bit(stable_reg),
                .digital_gain_adjust_en(digital_gain_adjust_en),
                .digital_gain_adjust_tick(bit_tick && two_bit_reg == 2'h0),
                .sample_out(sample_rail[r])
            );
        end
    endgenerate
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign amp_gain = amp_gain_reg;
    assign input_impedance_sel = imp_reg;
    assign filter_mant = mant_out_reg;
    assign filter_shift = shift_out_reg;
    assign dc_cancel_cutoff_field = dcc_out_reg;
    assign sample_i = sample_rail[0];
    assign sample_q = sample_rail[1];
endmodule : rgc_top
`default_nettype wire

// ---- hdl/rgc_pkg.sv ----
// rgc_pkg: constants, types and register map of the receive gain / channel filter control block.
// assumes a single pclk domain and an apb slave in the top module.
//
// Contract
// - code 000 hands gain to the loop
// - codes 001..110 fix gain, 111 reserved
// - wait until strength beats threshold twice running
// - pick gain, show it, hold it
// - packet mode, no auto restart: keep gain
// - auto restart after fifo empty plus delay
// - restart bit write returns to waiting
// - use correction bandwidth during startup correction
// - reference level from noise terms and bandwidth
// - digital gain readjusts every two bits
// - digital gain same in every mode
// - one-bit converter streams are decimated
// - channel filter is sixteen-tap fir
// - bandwidth from mantissa, exponent plus 2/3
// - mantissa 00/01/10 means 16/20/24
// - dc cutoff 16 percent halving, reset 010
`default_nettype none
package rgc_pkg;
    localparam logic [7:0] RGC_AMP_CONTROL_OFF = 8'h00;
    localparam logic [7:0] RGC_THRESHOLD_OFF = 8'h04;
    localparam logic [7:0] RGC_BANDWIDTH_OFF = 8'h08;
    localparam logic [7:0] RGC_CORR_BW_OFF = 8'h0c;
    localparam logic [7:0] RGC_DIG_GAIN_OFF = 8'h10;
    localparam logic [7:0] RGC_CONTROL_OFF = 8'h14;
    localparam logic [7:0] RGC_STATUS_OFF = 8'h18;
    localparam logic [7:0] RGC_REF_LEVEL_OFF = 8'h1c;
    localparam logic [7:0] RGC_BIT_PERIOD_OFF = 8'h20;
    // amp_control_reg fields
    localparam int RGC_GSEL_LSB = 0;
    localparam int RGC_CURGAIN_LSB = 3;
    localparam int RGC_ZIN_BIT = 7;
    // bandwidth_reg fields
    localparam int RGC_EXP_LSB = 0;
    localparam int RGC_MANT_LSB = 3;
    localparam int RGC_DCC_LSB = 5;
    // control register fields
    localparam int RGC_RESTART_BIT = 0;
    localparam int RGC_AUTORST_BIT = 1;
    localparam int RGC_PKTMODE_BIT = 2;
    localparam int RGC_OOK_BIT = 3;
    localparam int RGC_RXEN_BIT = 4;
    localparam int RGC_CORR_BIT = 5;
    localparam int RGC_DELAY_LSB = 8;
    // reset values
    localparam logic [7:0] RGC_AMP_RESET = 8'h00;
    localparam logic [7:0] RGC_THRESH_RESET = 8'he4;
    localparam logic [7:0] RGC_BW_RESET = 8'h55;
    localparam logic [7:0] RGC_CORR_BW_RESET = 8'h8b;
    localparam logic [7:0] RGC_DIG_GAIN_RESET = 8'h30;
    localparam logic [15:0] RGC_BIT_PERIOD_RESET = 16'h0064;
    // gain codes
    localparam logic [2:0] RGC_GAIN_AUTO = 3'h0;
    localparam logic [2:0] RGC_GAIN_MAX = 3'h1;
    localparam logic [2:0] RGC_GAIN_MIN = 3'h6;
    localparam logic [2:0] RGC_GAIN_RSVD = 3'h7;
    localparam int RGC_CONSEC_NEEDED = 2;
    localparam int RGC_DIGITAL_GAIN_ADJUST_BITS = 2;
    localparam int RGC_FIR_TAPS = 16;
    localparam int RGC_DECIM = 8;
    // reference level terms in dB (negative thermal floor as magnitude)
    localparam int RGC_THERMAL_DB = 174;
    localparam int RGC_NF_DB = 7;
    localparam int RGC_SNR_DB = 8;
    localparam int RGC_FADE_DB = 5;
    // inter-packet delay unit in bit periods
    localparam int RGC_DELAY_UNIT = 1;

    typedef enum logic [3:0] {
        RGC_ST_IDLE = 4'b0001,
        RGC_ST_WAIT = 4'b0010,
        RGC_ST_PICK = 4'b0100,
        RGC_ST_HOLD = 4'b1000
    } rgc_state_t;

    typedef struct packed {
        logic [2:0] mant_sel;
        logic [2:0] exponent;
        logic ook;
    } rgc_bw_cfg_t;

    typedef struct packed {
        logic [3:0] shift;
        logic [4:0] mant;
    } rgc_bw_dec_t;
endpackage : rgc_pkg
`default_nettype wire

// ---- hdl/rgc_bw_decode.sv ----
// rgc_bw_decode: bandwidth mantissa/exponent decode to divisor form.
// assumes pure combinational use inside the top.
`default_nettype none
module rgc_bw_decode
    import rgc_pkg::*;
(
    input wire rgc_pkg::rgc_bw_cfg_t cfg,
    output logic [4:0] mant_value,
    output logic [3:0] shift_total,
    output logic [6:0] ref_db
);
    logic [3:0] log2bw;
    always_comb begin
        if (cfg.mant_sel[1:0] == 2'b00) begin
            mant_value = 5'd16;
        end else if (cfg.mant_sel[1:0] == 2'b01) begin
            mant_value = 5'd20;
        end else begin
            mant_value = 5'd24;
        end
        shift_total = {1'b0, cfg.exponent} + (cfg.ook ? 4'd3 : 4'd2);
        // log2 of fxosc/bandwidth, coarse: 3 dB per octave of 2*bw
        log2bw = shift_total + 4'd4;
        // reference magnitude below 0 dBm; 10log(2bw) with 32 MHz crystal
        ref_db = 7'(RGC_THERMAL_DB - RGC_NF_DB - RGC_SNR_DB - RGC_FADE_DB - 78 + 3 * int'(log2bw));
    end
endmodule : rgc_bw_decode
`default_nettype wire

// ---- hdl/rgc_dsp_path.sv ----
// rgc_dsp_path: decimator, sixteen-tap fir and digital gain stage for one rail.
// assumes one-bit converter input sampled at pclk.
`default_nettype none
module rgc_dsp_path
    import rgc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic adc_bit,
    input wire logic digital_gain_adjust_en,
    input wire logic digital_gain_adjust_tick,
    output logic [11:0] sample_out
);
    import rgc_pkg::*;
    logic [3:0] acc_reg;
    logic [2:0] dec_cnt_reg;
    logic [3:0] taps_reg [RGC_FIR_TAPS];
    wire logic [3:0] taps_next [RGC_FIR_TAPS];
    logic [11:0] fir_sum;
    logic [2:0] dg_shift_reg;
    logic [11:0] out_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg <= 4'h0;
            dec_cnt_reg <= 3'h0;
        end else begin
            dec_cnt_reg <= dec_cnt_reg + 3'h1;
            acc_reg <= (dec_cnt_reg == 3'h7) ? {3'h0, adc_bit} : acc_reg + {3'h0, adc_bit};
        end
    end
    // one shift process; the loop only wires each tap to its neighbour
    genvar t;
    generate
        for (t = 0; t < RGC_FIR_TAPS; t++) begin : g_tap
            if (t == 0) begin : g_head
                assign taps_next[t] = acc_reg;
            end else begin : g_body
                assign taps_next[t] = taps_reg[t - 1];
            end
        end
    endgenerate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            taps_reg <= '{default: 4'h0};
        end else if (dec_cnt_reg == 3'h7) begin
            taps_reg <= taps_next;
        end
    end
    always_comb begin
        fir_sum = 12'h000;
        for (int i = 0; i < RGC_FIR_TAPS; i++) begin
            fir_sum = fir_sum + {8'h00, taps_reg[i]};
        end
    end
    // gain step each two bits regardless of mode or amp freeze
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dg_shift_reg <= 3'h0;
        end else if (digital_gain_adjust_en && digital_gain_adjust_tick) begin
            if (out_reg[11] && dg_shift_reg != 3'h0) begin
                dg_shift_reg <= dg_shift_reg - 3'h1;
            end else if (!out_reg[10] && dg_shift_reg != 3'h7) begin
                dg_shift_reg <= dg_shift_reg + 3'h1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg <= 12'h000;
        end else begin
            out_reg <= digital_gain_adjust_en ? (fir_sum << dg_shift_reg) : fir_sum;
        end
    end
    assign sample_out = out_reg;
endmodule : rgc_dsp_path
`default_nettype wire

// ---- verification/rgc_sva.sv ----
// rgc_sva: port-level checks of rgc_top.
// assumes one pclk domain; attached by the bind at the foot.
`default_nettype none
module rgc_sva
    import rgc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] amp_gain,
    input wire logic [4:0] filter_mant,
    input wire logic [2:0] dc_cancel_cutoff_field
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable && pready && pwrite;
    a_ready_setup: assert property (psel && !penable |=> pready) else $error("ready late");
    a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
    a_unmapped_err: assert property (psel && !penable && paddr > RGC_BIT_PERIOD_OFF |=> pslverr) else $error("no error");
    a_gain_range: assert property (amp_gain inside {[3'h1:3'h6]}) else $error("bad gain code");
    a_manual_gain: assert property (acc && paddr == RGC_AMP_CONTROL_OFF && pwdata[2:0] inside {[3'h1:3'h6]}
        |-> ##2 amp_gain == $past(pwdata[2:0], 2)) else $error("manual gain lost");
    a_reserved_keeps: assert property (acc && paddr == RGC_AMP_CONTROL_OFF && pwdata[2:0] == RGC_GAIN_RSVD
        |=> $stable(amp_gain) [*2]) else $error("reserved code moved gain");
    a_dcc_follows: assert property (acc && paddr == RGC_BANDWIDTH_OFF
        |-> ##2 dc_cancel_cutoff_field == $past(pwdata[7:5], 2)) else $error("dc cutoff lost");
    a_mant_decode: assert property (filter_mant inside {5'h10, 5'h14, 5'h18}) else $error("bad mantissa");
    c_ctrl_write: cover property (acc && paddr == RGC_CONTROL_OFF);
    c_refused: cover property (pslverr);
    c_gain_moves: cover property ($changed(amp_gain));
endmodule // rgc_sva
bind rgc_top rgc_sva u_sva (.*);
`default_nettype wire

// ---- verification/rgc_far_model.sv ----
// rgc_far_model: far transmitter strength samples and converter bits.
// assumes bench clock; mode 0 quiet, 1 weak, 2 strong, 3 alternating.
`default_nettype none
module rgc_far_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] mode,
    output logic [7:0] signal_strength_value,
    output logic strength_valid,
    output logic adc_i_bit,
    output logic adc_q_bit
);
    logic [2:0] cnt;
    logic smp;
    assign smp = mode != 2'h0 && cnt[1:0] == 2'h3;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 3'h0;
            strength_valid <= 1'b0;
            signal_strength_value <= 8'h00;
        end else begin
            cnt <= cnt + 3'h1;
            strength_valid <= smp;
            // weak level in mode 1, steady strong in mode 2, alternating in mode 3; value not held between samples
            signal_strength_value <= !smp ? ~signal_strength_value : (mode[1] && (!mode[0] || cnt[2])) ? 8'hc0 : 8'h10;
        end
    end
    always_ff @(posedge pclk) begin
        // strong carrier drives both converters to full scale
        adc_i_bit <= mode == 2'h2 ? 1'b1 : 1'($urandom);
        adc_q_bit <= mode == 2'h2 ? 1'b1 : 1'($urandom);
    end
endmodule // rgc_far_model
`default_nettype wire

// ---- verification/tb.sv ----
// tb: apb bench for rgc_top beside the far-side strength model.
// assumes one access cycle per transfer and a 4 ns pclk.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rgc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fifo_empty = 1'b0;
    logic packet_done = 1'b0, pready, pslverr, strength_valid, adc_i_bit, adc_q_bit, input_impedance_sel;
    logic [1:0] mode = 2'h0;
    logic [2:0] amp_gain, dc_cancel_cutoff_field;
    logic [3:0] filter_shift;
    logic [4:0] filter_mant;
    logic [7:0] paddr = 8'h00, signal_strength_value, bw;
    logic [11:0] sample_i, sample_q;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [64:0] expq[$];
    int n_errors = 0, checked = 0, cyc = 0;
    rgc_top dut (.*);
    rgc_far_model far (.*);
    initial forever #2 pclk = ~pclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, input logic e);
        expq.push_back({e, m, v});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic st(input logic [31:0] v);
        repeat (40) @(posedge pclk);
        rd(RGC_STATUS_OFF, 32'hf, v, 1'b0);
    endtask
    task automatic final_report;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge pclk) begin : watch
        logic [64:0] e;
        cyc++;
        if (psel && penable && pready && !pwrite && expq.size() > 0) begin
            e = expq.pop_front();
            chk(32'(pslverr), 32'(e[64]));
            chk(prdata & e[63:32], e[31:0]);
        end
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        void'($urandom(73));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(RGC_BANDWIDTH_OFF, 32'hff, 32'h55, 1'b0);
        rd(8'h24, 32'hffffffff, 32'h0, 1'b1);
        for (int g = 1; g < 8; g++) begin
            bus(1'b1, RGC_AMP_CONTROL_OFF, 32'(g));
            repeat (3) @(posedge pclk);
            chk(32'(amp_gain), 32'(g == 7 ? 6 : g));
        end
        for (int k = 0; k < 8; k++) begin
            bw = {3'($urandom), 2'($urandom % 3), 3'($urandom)};
            bus(1'b1, RGC_CONTROL_OFF, 32'(k[0]) << RGC_OOK_BIT);
            bus(1'b1, RGC_BANDWIDTH_OFF, 32'(bw));
            repeat (3) @(posedge pclk);
            chk(32'(filter_mant), 32'(16 + 4 * bw[4:3]));
            chk(32'(filter_shift), 32'(bw[2:0] + 2 + k[0]));
            chk(32'(dc_cancel_cutoff_field), 32'(bw[7:5]));
        end
        bus(1'b1, RGC_DIG_GAIN_OFF, 32'h20);
        bus(1'b1, RGC_AMP_CONTROL_OFF, 32'h80);
        bus(1'b1, RGC_THRESHOLD_OFF, 32'h80);
        bus(1'b1, RGC_BIT_PERIOD_OFF, 32'h4);
        mode <= 2'h3;
        bus(1'b1, RGC_CONTROL_OFF, 32'h0234);
        st(32'h2);
        chk(32'(filter_mant), 32'h14);
        mode <= 2'h2;
        st(32'h8);
        chk(32'(filter_shift), 32'(bw[2:0] + 2));
        chk(32'(amp_gain), 32'h3);
        chk(32'(input_impedance_sel), 32'h1);
        rd(RGC_AMP_CONTROL_OFF, 32'hb8, 32'h98, 1'b0);
        packet_done <= 1'b1;
        fifo_empty <= 1'b1;
        st(32'h8);
        mode <= 2'h0;
        bus(1'b1, RGC_CONTROL_OFF, 32'h0231);
        st(32'h2);
        rd(RGC_CONTROL_OFF, 32'h1, 32'h0, 1'b0);
        {packet_done, fifo_empty, mode} <= 4'h2;
        bus(1'b1, RGC_CONTROL_OFF, 32'h0236);
        st(32'h8);
        {packet_done, mode} <= 3'h4;
        st(32'h8);
        fifo_empty <= 1'b1;
        st(32'h2);
        bus(1'b1, RGC_DIG_GAIN_OFF, 32'h0);
        mode <= 2'h2;
        repeat (200) @(posedge pclk);
        chk(32'(sample_i), RGC_FIR_TAPS * RGC_DECIM);
        chk(32'(sample_q), RGC_FIR_TAPS * RGC_DECIM);
        final_report();
    end
endmodule // tb
`default_nettype wire
